// [hdl/pit_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// - Leave one idle turnaround clock before another agent drives a shared line
// - Target advances the burst address itself for every data word
// - Address phase: frame, address and command driven; ready and select float
// - Read target claims with select, then drives each word with ready
// - Target holds its read word unchanged until the initiator takes it
// - After the last word handshakes go inactive one clock, frame floats
// - Write data follows the address; target latches when both readies low
// - An unready target inserts one wait state per clock
// - As target the block never disconnects early
// - Disconnect: stop, word moves if both ready, frame drops, stop released
// - After early termination the initiator waits two clocks, then retries
// - As target the block never signals a target abort
// - Target abort: select and ready released with stop, no data moved
// - Initiator reports a target abort to the host
// - Initiator requests, waits for grant and an idle frame and ready
// - A withdrawn grant still lets the current transfer finish
// - Unclaimed within five clocks: end cycle, ready one clock, report
// - Never starts a locked access; as target marks itself locked
// - Lock holds only if the data phase completes
// - A locked target refuses initiators other than the lock owner
// - Lock drops when lock and frame are both seen released
module pit_top (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic [31:0] AD_I,
   output logic [31:0] AD_O,
   output logic AD_OE_N,
   input wire logic [3:0] CBE_I,
   output logic [3:0] CBE_O,
   output logic CBE_OE_N,
   input wire logic FRAME_N_I,
   output logic FRAME_N_O,
   output logic FRAME_N_OE_N,
   input wire logic IRDY_N_I,
   output logic IRDY_N_O,
   output logic IRDY_N_OE_N,
   input wire logic TRDY_N_I,
   output logic TRDY_N_O,
   output logic TRDY_N_OE_N,
   input wire logic DEVSEL_N_I,
   output logic DEVSEL_N_O,
   output logic DEVSEL_N_OE_N,
   input wire logic STOP_N_I,
   output logic STOP_N_O,
   output logic STOP_N_OE_N,
   input wire logic LOCK_N_I,
   output logic REQ_N,
   input wire logic GNT_N,
   input wire logic MST_START,
   input wire logic MST_WRITE,
   input wire logic [31:0] MST_ADDR,
   input wire logic [7:0] MST_LEN,
   input wire logic [31:0] MST_WDATA,
   output logic MST_WD_TAKE,
   output logic [31:0] MST_RDATA,
   output logic MST_RD_VALID,
   output logic MST_BUSY,
   output logic MST_DONE,
   output logic MST_TGT_ABORT,
   output logic MST_NO_CLAIM,
   input wire logic TGT_WR_READY,
   output logic TGT_WR_VALID,
   output logic [31:0] TGT_WR_ADDR,
   output logic [31:0] TGT_WR_DATA,
   output logic [3:0] TGT_WR_BE,
   output logic TGT_RD_REQ,
   output logic [31:0] TGT_RD_ADDR,
   input wire logic TGT_RD_VALID,
   input wire logic [31:0] TGT_RD_DATA,
   output logic TGT_LOCKED
);
   pit_pkg::pit_mst_e ms, next_ms;
   logic [31:0] addr, next_addr, wdat, next_wdat, next_rdata;
   logic [7:0] rem, next_rem;
   logic [2:0] cnt, next_cnt;
   logic wr, next_wr, wheld, next_wheld, claimed, next_claimed;
   logic retry, next_retry, next_rdv, next_done, next_tab, next_nc;
   logic s_addr, s_data, s_fin, s_turn, s_wait, last, xfer, take;
   logic m_ad_oe, m_drv;
   logic [31:0] t_ad;
   logic t_ad_oe, t_trdy_n, t_devsel_n, t_drv;
   // ==========================================================
   // Initiator decode
   assign s_addr = ms == pit_pkg::M_ADDR;
   assign s_data = ms == pit_pkg::M_DATA;
   assign s_fin = ms == pit_pkg::M_FIN;
   assign s_turn = ms == pit_pkg::M_TURN;
   assign s_wait = ms == pit_pkg::M_WAIT;
   assign last = rem == pit_pkg::LEN_ONE;
   assign xfer = (s_data || s_fin) && !TRDY_N_I;
   assign take = wr && ((s_addr && !wheld) ||
                        (s_data && xfer && !last && STOP_N_I));
   assign m_drv = s_addr || s_data || s_fin;
   assign m_ad_oe = s_addr || (wr && (s_data || s_fin));
   assign MST_WD_TAKE = take;
   assign MST_BUSY = ms != pit_pkg::M_IDLE;
   // ==========================================================
   // Initiator state machine
   always_comb
   begin
      next_ms = ms;
      next_addr = addr;
      next_rem = rem;
      next_wr = wr;
      next_wdat = wdat;
      next_wheld = wheld;
      next_cnt = cnt;
      next_claimed = claimed;
      next_retry = retry;
      next_rdata = MST_RDATA;
      next_rdv = 1'b0;
      next_done = 1'b0;
      next_tab = 1'b0;
      next_nc = 1'b0;
      if (xfer)
      begin
         next_rem = rem - pit_pkg::LEN_ONE;
         next_addr = pit_pkg::pit_step(addr);
         next_wheld = 1'b0;
         if (!wr)
         begin
            next_rdata = AD_I;
            next_rdv = 1'b1;
         end
      end
      if (take)
      begin
         next_wdat = MST_WDATA;
         next_wheld = 1'b1;
      end
      case (ms)
         pit_pkg::M_IDLE:
            if (MST_START && MST_LEN != pit_pkg::LEN_NONE)
            begin
               next_ms = pit_pkg::M_REQ;
               next_addr = MST_ADDR;
               next_rem = MST_LEN;
               next_wr = MST_WRITE;
               next_wheld = 1'b0;
            end
         pit_pkg::M_REQ:
            if (!GNT_N && FRAME_N_I && IRDY_N_I)
               next_ms = pit_pkg::M_ADDR;
         pit_pkg::M_ADDR:
         begin
            next_ms = pit_pkg::M_DATA;
            next_cnt = '0;
            next_claimed = 1'b0;
            next_retry = 1'b0;
         end
         pit_pkg::M_DATA:
         begin
            if (!DEVSEL_N_I)
               next_claimed = 1'b1;
            if (!STOP_N_I)
            begin
               if (DEVSEL_N_I)
                  next_tab = 1'b1;
               else
                  next_retry = 1'b1;
               next_ms = last ? pit_pkg::M_TURN : pit_pkg::M_FIN;
            end
            else if (xfer)
            begin
               if (last)
                  next_ms = pit_pkg::M_TURN;
            end
            else if (DEVSEL_N_I && !claimed)
            begin
               next_cnt = cnt + 3'h1;
               if (cnt == pit_pkg::NOCLAIM_LAST)
               begin
                  next_nc = 1'b1;
                  next_ms = last ? pit_pkg::M_TURN : pit_pkg::M_FIN;
               end
            end
         end
         pit_pkg::M_FIN:
            next_ms = pit_pkg::M_TURN;
         pit_pkg::M_TURN:
            if (retry && rem != pit_pkg::LEN_NONE)
            begin
               next_ms = pit_pkg::M_WAIT;
               next_cnt = '0;
            end
            else
            begin
               next_ms = pit_pkg::M_IDLE;
               next_done = 1'b1;
            end
         pit_pkg::M_WAIT:
         begin
            next_cnt = cnt + 3'h1;
            if (cnt == pit_pkg::RETRY_LAST)
               next_ms = pit_pkg::M_REQ;
         end
         default:
            next_ms = pit_pkg::M_IDLE;
      endcase
   end
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         ms <= pit_pkg::M_IDLE;
         addr <= '0;
         rem <= '0;
         wr <= 1'b0;
         wdat <= '0;
         wheld <= 1'b0;
         cnt <= '0;
         claimed <= 1'b0;
         retry <= 1'b0;
         MST_RDATA <= '0;
         MST_RD_VALID <= 1'b0;
         MST_DONE <= 1'b0;
         MST_TGT_ABORT <= 1'b0;
         MST_NO_CLAIM <= 1'b0;
      end
      else
      begin
         ms <= next_ms;
         addr <= next_addr;
         rem <= next_rem;
         wr <= next_wr;
         wdat <= next_wdat;
         wheld <= next_wheld;
         cnt <= next_cnt;
         claimed <= next_claimed;
         retry <= next_retry;
         MST_RDATA <= next_rdata;
         MST_RD_VALID <= next_rdv;
         MST_DONE <= next_done;
         MST_TGT_ABORT <= next_tab;
         MST_NO_CLAIM <= next_nc;
      end
   end
   // ==========================================================
   // Target side
   pit_target u_tgt (
      .clk(CORE_CLK),
      .rst(RST),
      .ad_i(AD_I),
      .cbe_i(CBE_I),
      .frame_n_i(FRAME_N_I),
      .irdy_n_i(IRDY_N_I),
      .lock_n_i(LOCK_N_I),
      .own(m_drv),
      .ad_o(t_ad),
      .ad_oe(t_ad_oe),
      .trdy_n_o(t_trdy_n),
      .devsel_n_o(t_devsel_n),
      .drv(t_drv),
      .wr_ready(TGT_WR_READY),
      .wr_valid(TGT_WR_VALID),
      .wr_addr(TGT_WR_ADDR),
      .wr_data(TGT_WR_DATA),
      .wr_be(TGT_WR_BE),
      .rd_req(TGT_RD_REQ),
      .rd_addr(TGT_RD_ADDR),
      .rd_valid(TGT_RD_VALID),
      .rd_data(TGT_RD_DATA),
      .locked(TGT_LOCKED)
   );
   // ==========================================================
   // Pad drive
   // Frame floats in turnaround while ready is driven high once
   assign FRAME_N_O = !(s_addr || (s_data && !last));
   assign FRAME_N_OE_N = !m_drv;
   assign IRDY_N_O = !(s_data || s_fin);
   assign IRDY_N_OE_N = !(s_data || s_fin || s_turn);
   assign CBE_O = s_addr ? (wr ? pit_pkg::CMD_MEM_WR : pit_pkg::CMD_MEM_RD)
                         : pit_pkg::BE_ALL;
   assign CBE_OE_N = !m_drv;
   assign AD_O = m_ad_oe ? (s_addr ? addr : wdat) : t_ad;
   assign AD_OE_N = !(m_ad_oe || t_ad_oe);
   assign REQ_N = ms != pit_pkg::M_REQ;
   assign TRDY_N_O = t_trdy_n;
   assign TRDY_N_OE_N = !t_drv;
   assign DEVSEL_N_O = t_devsel_n;
   assign DEVSEL_N_OE_N = !t_drv;
   // Stop is only ever driven inactive
   assign STOP_N_O = 1'b1;
   assign STOP_N_OE_N = !t_drv;
   // ==========================================================
   // Checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   sequence seq_unclaimed;
      (s_data && DEVSEL_N_I && STOP_N_I && !claimed)[*5];
   endsequence
   sequence seq_retry_gap;
      s_wait[*2] ##1 (ms == pit_pkg::M_REQ);
   endsequence
   chk_bus_idle: assert property
      ($rose(s_addr) |-> $past(FRAME_N_I) && $past(IRDY_N_I) &&
       !$past(GNT_N))
      else $error("address phase started on a busy or ungranted bus");
   chk_addr_phase: assert property
      (s_addr |-> !FRAME_N_O && !FRAME_N_OE_N && !AD_OE_N &&
       IRDY_N_OE_N && AD_O == addr)
      else $error("address phase drive wrong");
   chk_no_claim: assert property
      (seq_unclaimed |=> MST_NO_CLAIM && !s_data)
      else $error("unclaimed cycle not ended after five clocks");
   chk_irdy_after: assert property
      (s_fin |-> !IRDY_N_O && FRAME_N_O ##1 s_turn && IRDY_N_O)
      else $error("ready not held one clock after frame removal");
   chk_retry_wait: assert property
      ($rose(s_wait) |-> seq_retry_gap)
      else $error("retry not issued after two clocks");
   chk_tgt_abort: assert property
      (s_data && !STOP_N_I && DEVSEL_N_I |=> MST_TGT_ABORT &&
       (s_fin || s_turn))
      else $error("target abort not reported");
   chk_turn_float: assert property
      (s_turn |-> FRAME_N_OE_N && !IRDY_N_OE_N && IRDY_N_O &&
       CBE_OE_N && !m_ad_oe)
      else $error("initiator turnaround drive wrong");
   chk_grant_kept: assert property
      (s_data && !last && STOP_N_I && !DEVSEL_N_I |=> s_data)
      else $error("burst left before its final transfer");
endmodule
`default_nettype wire

// [hdl/pit_pkg.sv]
`default_nettype none
package pit_pkg;
   // ==========================================================
   // Bus commands and byte enables
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] BE_ALL = 4'h0;
   // ==========================================================
   // Target window and burst step
   localparam logic [31:0] TGT_BASE = 32'h1000_0000;
   localparam logic [31:0] TGT_MASK = 32'hFFFF_0000;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;
   // ==========================================================
   // Timing, in bus clocks, and burst lengths, in words
   localparam int NOCLAIM_CLKS = 5;
   localparam int RETRY_CLKS = 2;
   localparam logic [2:0] NOCLAIM_LAST = 3'(NOCLAIM_CLKS - 1);
   localparam logic [2:0] RETRY_LAST = 3'(RETRY_CLKS - 1);
   localparam logic [7:0] LEN_ONE = 8'h01;
   localparam logic [7:0] LEN_NONE = 8'h00;
   // ==========================================================
   // State types
   typedef enum logic [2:0]
   {
      M_IDLE, M_REQ, M_ADDR, M_DATA, M_FIN, M_TURN, M_WAIT
   } pit_mst_e;
   typedef enum logic [1:0] {T_IDLE, T_DEC, T_DATA, T_TURN} pit_tgt_e;
   // ==========================================================
   // Shared arithmetic and decode
   function automatic logic [31:0] pit_step(input logic [31:0] a);
      return a + WORD_STEP;
   endfunction
   function automatic logic pit_hit(input logic [31:0] a,
                                    input logic [3:0] c);
      return ((a & TGT_MASK) == TGT_BASE) &&
             (c == CMD_MEM_RD || c == CMD_MEM_WR);
   endfunction
endpackage
`default_nettype wire

// [hdl/pit_lock.sv]
`timescale 1ns/1ps
`default_nettype none
module pit_lock (
   input wire logic clk,
   input wire logic rst,
   input wire logic dec,
   input wire logic alock_n,
   input wire logic lock_n_i,
   input wire logic frame_n_i,
   input wire logic fin,
   output logic locked,
   output logic accept
);
   logic pend;
   logic next_pend;
   logic next_locked;
   // ==========================================================
   // Lock tracking
   // Owner: lock free in the address phase, asserted right after
   assign accept = !locked || (alock_n && !lock_n_i);
   always_comb
   begin
      next_pend = pend;
      next_locked = locked;
      if (dec)
         next_pend = !lock_n_i;
      else if (fin || (frame_n_i && lock_n_i))
         next_pend = 1'b0;
      if (frame_n_i && lock_n_i)
         next_locked = 1'b0;
      if (fin && pend)
         next_locked = 1'b1;
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pend <= 1'b0;
         locked <= 1'b0;
      end
      else
      begin
         pend <= next_pend;
         locked <= next_locked;
      end
   end
   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_lock_drop: assert property
      (locked && frame_n_i && lock_n_i && !(fin && pend) |=> !locked)
      else $error("lock kept after lock and frame released");
   chk_lock_done: assert property
      ($rose(locked) |-> $past(fin) && $past(pend))
      else $error("lock set without a completed locked phase");
endmodule
`default_nettype wire

// [hdl/pit_target.sv]
`timescale 1ns/1ps
`default_nettype none
module pit_target (
   input wire logic clk,
   input wire logic rst,
   input wire logic [31:0] ad_i,
   input wire logic [3:0] cbe_i,
   input wire logic frame_n_i,
   input wire logic irdy_n_i,
   input wire logic lock_n_i,
   input wire logic own,
   output logic [31:0] ad_o,
   output logic ad_oe,
   output logic trdy_n_o,
   output logic devsel_n_o,
   output logic drv,
   input wire logic wr_ready,
   output logic wr_valid,
   output logic [31:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_be,
   output logic rd_req,
   output logic [31:0] rd_addr,
   input wire logic rd_valid,
   input wire logic [31:0] rd_data,
   output logic locked
);
   pit_pkg::pit_tgt_e ts, next_ts;
   logic [31:0] addr, next_addr, next_ad, next_wa, next_wd;
   logic [3:0] next_wbe;
   logic rd, next_rd, frame_q, alock_n, next_alock_n;
   logic have, next_have, next_wv, accept, xfer, fin, s_data;
   // ==========================================================
   // Bus side decode
   assign s_data = ts == pit_pkg::T_DATA;
   assign xfer = s_data && !irdy_n_i && !trdy_n_o;
   assign fin = xfer && frame_n_i;
   assign drv = (ts == pit_pkg::T_DEC && accept) || s_data ||
                ts == pit_pkg::T_TURN;
   assign devsel_n_o = !s_data;
   assign trdy_n_o = !(s_data && (rd ? have : wr_ready));
   assign ad_oe = s_data && rd;
   assign rd_req = s_data && rd && !have;
   assign rd_addr = addr;
   // ==========================================================
   // Target state machine
   always_comb
   begin
      next_ts = ts;
      next_addr = addr;
      next_rd = rd;
      next_alock_n = alock_n;
      next_have = have;
      next_ad = ad_o;
      next_wv = 1'b0;
      next_wa = wr_addr;
      next_wd = wr_data;
      next_wbe = wr_be;
      case (ts)
         pit_pkg::T_IDLE:
            if (frame_q && !frame_n_i && !own &&
                pit_pkg::pit_hit(ad_i, cbe_i))
            begin
               next_ts = pit_pkg::T_DEC;
               next_addr = ad_i;
               next_rd = cbe_i == pit_pkg::CMD_MEM_RD;
               next_alock_n = lock_n_i;
               next_have = 1'b0;
            end
         pit_pkg::T_DEC:
            next_ts = accept ? pit_pkg::T_DATA : pit_pkg::T_IDLE;
         pit_pkg::T_DATA:
         begin
            if (rd_req && rd_valid)
            begin
               next_have = 1'b1;
               next_ad = rd_data;
            end
            if (xfer)
            begin
               next_addr = pit_pkg::pit_step(addr);
               next_have = 1'b0;
               next_wv = !rd;
               next_wa = addr;
               next_wd = ad_i;
               next_wbe = cbe_i;
            end
            if (fin)
               next_ts = pit_pkg::T_TURN;
         end
         pit_pkg::T_TURN:
            next_ts = pit_pkg::T_IDLE;
         default:
            next_ts = pit_pkg::T_IDLE;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ts <= pit_pkg::T_IDLE;
         addr <= '0;
         rd <= 1'b0;
         frame_q <= 1'b1;
         alock_n <= 1'b1;
         have <= 1'b0;
         ad_o <= '0;
         wr_valid <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
         wr_be <= '0;
      end
      else
      begin
         ts <= next_ts;
         addr <= next_addr;
         rd <= next_rd;
         frame_q <= frame_n_i;
         alock_n <= next_alock_n;
         have <= next_have;
         ad_o <= next_ad;
         wr_valid <= next_wv;
         wr_addr <= next_wa;
         wr_data <= next_wd;
         wr_be <= next_wbe;
      end
   end
   pit_lock u_lock (
      .clk(clk),
      .rst(rst),
      .dec(ts == pit_pkg::T_DEC && accept),
      .alock_n(alock_n),
      .lock_n_i(lock_n_i),
      .frame_n_i(frame_n_i),
      .fin(fin),
      .locked(locked),
      .accept(accept)
   );
   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_hold_word: assert property
      (s_data && rd && !trdy_n_o && irdy_n_i |=>
       $stable(ad_o) && !trdy_n_o)
      else $error("read word changed before it was taken");
   chk_addr_step: assert property
      (xfer && !frame_n_i |=> addr == $past(addr) + pit_pkg::WORD_STEP)
      else $error("burst address not advanced by one word");
   chk_claim_hold: assert property
      (s_data && !fin |=> s_data && !devsel_n_o)
      else $error("target left a claimed cycle early");
   chk_turn_release: assert property
      (fin |=> drv && devsel_n_o && trdy_n_o && !ad_oe ##1 !drv)
      else $error("target turnaround sequence wrong");
endmodule
`default_nettype wire

// [bench/pit_far.sv]
`timescale 1ns/1ps
`default_nettype none
// ======
// Far-side target answering the block's own accesses
module pit_far (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] mode,
   input wire logic frame_n,
   input wire logic irdy_n,
   input wire logic cmd0,
   input wire logic [31:0] ad,
   output logic trdy_n,
   output logic devsel_n,
   output logic stop_n,
   output logic oe,
   output logic [31:0] ad_o,
   output logic ad_oe,
   output logic [31:0] wdat
);
   // Modes: 0 normal, 1 abort, 2 silent, 3 disconnect
   localparam logic [31:0] KR = 32'hA5A5_0000;
   logic act, fin, rd, fq, dn, xf;
   logic [31:0] a;
   assign xf = !irdy_n && !trdy_n;
   always_ff @(posedge clk)
   begin
      fq <= frame_n;
      if (rst || fin)
      begin
         act <= 1'b0;
         fin <= 1'b0;
         oe <= 1'b0;
         ad_oe <= 1'b0;
      end
      else if (!act)
      begin
         if (fq && !frame_n && mode != 2'h2)
         begin
            act <= 1'b1;
            oe <= 1'b1;
            dn <= 1'b0;
            a <= ad;
            rd <= !cmd0;
            devsel_n <= (mode == 2'h1);
            stop_n <= (mode != 2'h1);
            trdy_n <= 1'b1;
         end
      end
      else if (frame_n && (xf || !stop_n))
      begin
         // One clock driven idle, then released
         fin <= 1'b1;
         devsel_n <= 1'b1;
         trdy_n <= 1'b1;
         stop_n <= 1'b1;
         ad_oe <= 1'b0;
         if (xf && !rd)
            wdat <= ad;
      end
      else
      begin
         stop_n <= (mode == 2'h0);
         trdy_n <= (mode == 2'h1) || (mode == 2'h3 && (xf || dn));
         dn <= dn || xf;
         ad_oe <= rd && mode != 2'h1;
         if (xf)
         begin
            a <= a + 32'h4;
            ad_o <= (a + 32'h4) ^ KR;
            if (!rd)
               wdat <= ad;
         end
         else
            ad_o <= a ^ KR;
      end
   end
endmodule
`default_nettype wire

// [bench/pci_initiator_target_port_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pci_initiator_target_port_tb_top;
   localparam logic [31:0] KR = 32'hA5A5_0000;
   localparam logic [31:0] KT = 32'h5A00_0000;
   localparam logic [31:0] KQ = 32'h00C3_0000;
   localparam logic [31:0] KW = 32'hC0DE_0000;
   logic clk, rst, gnt_n, start, mw, twr_rdy, trv, tlk, fq, tf, ti, t_oe;
   logic t_adoe, fr_oen, ir_oen, tr_oen, dv_oen, st_oen, ad_oen, cbe_oen;
   logic fr_o, ir_o, tr_o, dv_o, st_o, req_n, wd_take, rd_v, done, tab;
   logic ncl, tw_v, trq, locked, p_tr, p_dv, p_st, p_oe, p_adoe;
   logic fr_w, ir_w, tr_w, dv_w, st_w, busy;
   logic [1:0] mode;
   logic [3:0] t_cbe, cbe_o, cbe_w, tw_be;
   logic [7:0] ml;
   logic [31:0] ma, mwd, trd, t_ad, ad_o, ad_w, ad_q, rdata, tw_a, tw_d;
   logic [31:0] tra, p_ad, p_wd, rexp, texp;
   int n_errors, n_tests, cyc, dn, ab, nc, wk, rdn, k;
   assign fr_w = !fr_oen ? fr_o : t_oe ? tf : 1'b1;
   assign ir_w = !ir_oen ? ir_o : t_oe ? ti : 1'b1;
   assign tr_w = !tr_oen ? tr_o : p_oe ? p_tr : 1'b1;
   assign dv_w = !dv_oen ? dv_o : p_oe ? p_dv : 1'b1;
   assign st_w = !st_oen ? st_o : p_oe ? p_st : 1'b1;
   assign cbe_w = !cbe_oen ? cbe_o : t_oe ? t_cbe : 4'hF;
   assign ad_w = !ad_oen ? ad_o : p_adoe ? p_ad : t_adoe ? t_ad : ~ad_q;
   pit_top dut (.CORE_CLK(clk), .RST(rst), .AD_I(ad_w), .AD_O(ad_o),
      .AD_OE_N(ad_oen), .CBE_I(cbe_w), .CBE_O(cbe_o), .CBE_OE_N(cbe_oen),
      .FRAME_N_I(fr_w), .FRAME_N_O(fr_o), .FRAME_N_OE_N(fr_oen),
      .IRDY_N_I(ir_w), .IRDY_N_O(ir_o), .IRDY_N_OE_N(ir_oen),
      .TRDY_N_I(tr_w), .TRDY_N_O(tr_o), .TRDY_N_OE_N(tr_oen),
      .DEVSEL_N_I(dv_w), .DEVSEL_N_O(dv_o), .DEVSEL_N_OE_N(dv_oen),
      .STOP_N_I(st_w), .STOP_N_O(st_o), .STOP_N_OE_N(st_oen),
      .LOCK_N_I(tlk), .REQ_N(req_n), .GNT_N(gnt_n), .MST_START(start),
      .MST_WRITE(mw), .MST_ADDR(ma), .MST_LEN(ml), .MST_WDATA(mwd),
      .MST_WD_TAKE(wd_take), .MST_RDATA(rdata), .MST_RD_VALID(rd_v),
      .MST_BUSY(busy), .MST_DONE(done), .MST_TGT_ABORT(tab),
      .MST_NO_CLAIM(ncl), .TGT_WR_READY(twr_rdy), .TGT_WR_VALID(tw_v),
      .TGT_WR_ADDR(tw_a), .TGT_WR_DATA(tw_d), .TGT_WR_BE(tw_be),
      .TGT_RD_REQ(trq), .TGT_RD_ADDR(tra), .TGT_RD_VALID(trv),
      .TGT_RD_DATA(trd), .TGT_LOCKED(locked));
   pit_far far (.clk(clk), .rst(rst), .mode(mode), .frame_n(fr_w),
      .irdy_n(ir_w), .cmd0(cbe_w[0]), .ad(ad_w), .trdy_n(p_tr),
      .devsel_n(p_dv), .stop_n(p_st), .oe(p_oe), .ad_o(p_ad),
      .ad_oe(p_adoe), .wdat(p_wd));
   always #2 clk = ~clk;
   // ======
   // Checks and reports
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      n_tests++;
      if (s !== e)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic stop_test;
      if (n_errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      ad_q <= ad_w;
      fq <= fr_w;
      trv <= trq && !trv;
      trd <= tra ^ KQ;
      twr_rdy <= cyc[1];
      if (done) dn++;
      if (tab) ab++;
      if (ncl) nc++;
      if (wd_take)
      begin
         wk++;
         mwd <= KW + 32'(wk);
      end
      if (rd_v)
      begin
         chk("mst_rdata", rexp ^ KR, rdata);
         rexp += 32'h4;
         rdn++;
      end
      if (tw_v)
      begin
         chk("tgt_waddr", texp, tw_a);
         chk("tgt_wdata", texp ^ KT, tw_d);
         chk("tgt_wbe", 0, 32'(tw_be));
         texp += 32'h4;
      end
      if (fq && !fr_w && !fr_oen)
         chk("cmd", {31'h3, mw}, 32'(cbe_o));
      if (!ad_oen && p_adoe)
         chk("ad_clash", 0, 1);
      if (!st_oen)
         chk("stop", 1, 32'(st_o));
      if (cyc == 2000)
      begin
         n_errors++;
         stop_test();
      end
   end
   // ======
   // Block as initiator against the far-side model
   task automatic mst(input logic w, input logic [31:0] a,
                      input logic [7:0] n, input logic [1:0] m);
      int i;
      int d;
      d = dn;
      {rdn, wk, ab, nc} = '0;
      rexp = a;
      mode <= m;
      mw <= w;
      ma <= a;
      ml <= n;
      mwd <= KW;
      gnt_n <= 1'b1;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (3) @(posedge clk);
      chk("req", 0, 32'(req_n));
      chk("frame_oe", 1, 32'(fr_oen));
      chk("busy", 1, 32'(busy));
      for (i = 0; i < 80 && dn == d; i++)
      begin
         gnt_n <= rdn > 0 && m == 2'h0;
         @(posedge clk);
      end
      gnt_n <= 1'b0;
      @(posedge clk);
      chk("done", d + 1, dn);
      chk("rwords", (m == 2'h0 || m == 2'h3) && !w ? n : 0, rdn);
      if (w)
         chk("wdata", KW + n - 1, p_wd);
      chk("abort", m == 2'h1, ab);
      chk("noclaim", m == 2'h2, nc);
   endtask
   // ======
   // Bench as initiator against the block's target
   task automatic ini(input logic w, input logic [31:0] a, input int n,
                      input logic lk, output int got);
      int t;
      got = 0;
      @(posedge clk);
      t_oe <= 1'b1;
      tf <= 1'b0;
      t_ad <= a;
      t_adoe <= 1'b1;
      t_cbe <= {3'h3, w};
      @(posedge clk);
      if (lk)
         tlk <= 1'b0;
      ti <= 1'b0;
      t_cbe <= 4'h0;
      tf <= (n == 1);
      t_ad <= a ^ KT;
      t_adoe <= w;
      for (t = 0; t < 6 * n + 4 && got < n; t++)
      begin
         @(posedge clk);
         if (!ir_w && !tr_w)
         begin
            if (!w)
               chk("tgt_rdata", (a + 32'(4 * got)) ^ KQ, ad_w);
            got++;
            if (got < n)
            begin
               t_ad <= (a + 32'(4 * got)) ^ KT;
               tf <= (got >= n - 1);
               ti <= (got == 1);
            end
         end
         else if (t < 6 * n + 3)
            ti <= 1'b0;
      end
      ti <= 1'b1;
      tf <= 1'b1;
      t_adoe <= 1'b0;
      @(posedge clk);
      t_oe <= 1'b0;
   endtask
   initial
   begin
      {clk, rst, gnt_n, start, mw, twr_rdy, trv, tlk} = 8'h67;
      {tf, ti, t_cbe, mode, ml} = '1;
      {ma, mwd, trd, t_ad, ad_q, t_oe, t_adoe} = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      mst(1'b0, 32'h2000_0000, 8'h03, 2'h0);
      mst(1'b1, 32'h2000_0100, 8'h02, 2'h0);
      mst(1'b0, 32'h2000_0200, 8'h02, 2'h3);
      mst(1'b0, 32'h2000_0300, 8'h01, 2'h1);
      mst(1'b0, 32'h2000_0400, 8'h01, 2'h2);
      mode <= 2'h2;
      texp = pit_pkg::TGT_BASE;
      ini(1'b1, pit_pkg::TGT_BASE, 3, 1'b0, k);
      chk("wwords", 3, k);
      ini(1'b0, pit_pkg::TGT_BASE + 32'h40, 3, 1'b1, k);
      chk("locked", 1, 32'(locked));
      ini(1'b1, pit_pkg::TGT_BASE, 1, 1'b0, k);
      chk("refused", 0, k);
      tlk <= 1'b1;
      repeat (3) @(posedge clk);
      chk("unlocked", 0, 32'(locked));
      stop_test();
   end
endmodule
`default_nettype wire
